// ==== mbs_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides and a flush input
`timescale 1ns/100ps
module mbs_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  input  wire logic [W-1:0]               in_data,
  output logic                            in_ready,
  output logic                            out_valid,
  output logic [W-1:0]                    out_data,
  input  wire logic                       out_ready,
  output logic [$clog2(DEPTH):0]          count
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [CW-1:0]           cnt;
  } mbs_fifo_st_t;

  mbs_fifo_st_t st_q;
  mbs_fifo_st_t st_d;
  logic         push;
  logic         pop;

  assign in_ready  = (st_q.cnt != CW'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data  = st_q.mem[st_q.rd_ptr];
  assign count     = st_q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.mem[st_q.wr_ptr] = in_data;
      st_d.wr_ptr           = (st_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_q.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      st_d.rd_ptr = (st_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_q.rd_ptr + 1'b1;
    end
    st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
    if (!rst_n || flush)
    begin
      st_d.wr_ptr = '0;
      st_d.rd_ptr = '0;
      st_d.cnt    = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    st_q <= st_d;
  end

endmodule

// ==== mbs_pkg.sv ====
// Shared constants for the memory boundary scan port
package mbs_pkg;

  // Scan chain geometry
  localparam int CHAIN_LEN = 67;

  // Chain positions (exit order, first bit out is position 1) that read as zero
  localparam int RSV_BALL_A_POS  = 56;
  localparam int RSV_BALL_B_POS  = 57;
  localparam int RSV_MAKER_POS   = 20;

  // Mask of chain indices (index = position - 1) that are forced low on capture
  localparam logic [CHAIN_LEN-1:0] CHAIN_ZERO_MASK =
    (67'(1) << (RSV_BALL_A_POS - 1)) |
    (67'(1) << (RSV_BALL_B_POS - 1)) |
    (67'(1) << (RSV_MAKER_POS - 1));

  // Reset value of the chain, and the clear and set levels of single level flops
  localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = '0;
  localparam logic                 BIT_CLR     = 1'b0;
  localparam logic                 BIT_SET     = 1'b1;

  // Command path buffering
  localparam int CMD_W      = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = $clog2(FIFO_DEPTH);
  localparam int FIFO_CW    = FIFO_AW + 1;

  // Core clock rate and minimum scan clock period
  localparam int CLK_PERIOD_PS  = 25_000;
  localparam int SCAN_TCK_MIN_NS = 40;

  // Levels crossing from the pins and scan domain into the core clock domain
  localparam int SYNC_W       = 5;
  localparam int SYNC_SEN     = 0;
  localparam int SYNC_MIRROR  = 1;
  localparam int SYNC_RESET   = 2;
  localparam int SYNC_GATE    = 3;
  localparam int SYNC_SCAN_SERIAL_OUT    = 4;

endpackage

// ==== mbs_scan_port.sv ====
// Boundary scan test port of the memory device: scan chain, pin sharing and command gating
//
// Behaviour
// - Scan mode is on while the scan mode select pin is high and scan operation stops when it is low.
// - With capture/shift select low the chain loads from the pads, with it high the chain shifts one place.
// - Every scan input is sampled on the rising edge of the scan clock, which may be single or irregular pulses.
// - Chain data reaches the serial output only while the output gate has been registered high.
// - Serial scan data leaves on the lane 0 write strobe pin, and only while scan mode is selected.
// - The chain holds 67 positions in a fixed exit order and shifts out zeros once the last has left.
// - Positions of the two reserved balls and the reserved maker ball always read as zero.
// - Ball mirroring is disabled while in scan mode.
// - No command of any kind executes while scan mode select is asserted.
// - In scan mode address/control termination is set nominal and data termination is off, uncalibrated.
// - With scan mode select low the shared pins keep their ordinary memory roles.
`timescale 1ns/100ps
module mbs_scan_port
  import mbs_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        scan_clk,
  input  wire logic                        scan_mode_select,
  input  wire logic                        device_reset_pin,
  input  wire logic                        ball_mirror_select,
  input  wire logic [mbs_pkg::CHAIN_LEN-1:0] pad_level,
  input  wire logic                        lane0_write_strobe_i,
  output logic                             lane0_write_strobe_o,
  output logic                             lane0_write_strobe_oe,
  input  wire logic                        init_done,
  output logic                             mirror_active,
  output logic                             core_reset_level,
  output logic                             ca_term_nominal,
  output logic                             dq_term_off,
  output logic                             scan_active,
  output logic                             scan_used,
  input  wire logic                        cmd_in_valid,
  input  wire logic [mbs_pkg::CMD_W-1:0]   cmd_in_data,
  output logic                             cmd_in_ready,
  output logic                             cmd_out_valid,
  output logic [mbs_pkg::CMD_W-1:0]        cmd_out_data,
  input  wire logic                        cmd_out_ready
);

  import mbs_pkg::*;

  // ---------------------------------------------------------------
  // Scan clock domain: chain, output gate and serial data
  // ---------------------------------------------------------------

  // The scan clock is a pulse train from the tester. It cannot be
  // relied on to carry a reset, so this domain is cleared by the
  // select being low at an edge instead of by rst_n.
  typedef struct packed {
    logic [CHAIN_LEN-1:0] chain;
    logic                 gate;
    logic                 scan_serial_out;
  } mbs_scan_st_t;

  mbs_scan_st_t sc_q;
  mbs_scan_st_t sc_d;

  // On the scan clock the pin for device reset is the capture/shift
  // select and the mirror pin is the output gate.
  logic capture_shift_select;
  logic scan_output_gate;

  assign capture_shift_select = device_reset_pin;
  assign scan_output_gate     = ball_mirror_select;

  always_comb
  begin
    sc_d = sc_q;
    if (!scan_mode_select)
    begin
      sc_d.chain = CHAIN_RESET;
      sc_d.gate  = BIT_CLR;
    end
    else
    begin
      // Gate is taken on the same edge as the data it unlocks
      sc_d.gate = scan_output_gate;
      if (capture_shift_select)
      begin
        // Position 1 sits at index 0, next to the output; a zero enters at the far end
        sc_d.chain = {BIT_CLR, sc_q.chain[CHAIN_LEN-1:1]};
      end
      else
      begin
        sc_d.chain = pad_level & ~CHAIN_ZERO_MASK;
      end
    end
    // Serial bit shows the position now at the head of the chain
    sc_d.scan_serial_out = sc_d.chain[0];
  end

  always_ff @(posedge scan_clk)
  begin
    sc_q <= sc_d;
  end

  // ---------------------------------------------------------------
  // Core clock domain
  // ---------------------------------------------------------------

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_lvl;

  // Pins and scan domain levels cross with two flops each
  always_comb
  begin
    sync_in              = '0;
    sync_in[SYNC_SEN]    = scan_mode_select;
    sync_in[SYNC_MIRROR] = ball_mirror_select;
    sync_in[SYNC_RESET]  = device_reset_pin;
    sync_in[SYNC_GATE]   = sc_q.gate;
    sync_in[SYNC_SCAN_SERIAL_OUT]   = sc_q.scan_serial_out;
  end

  mbs_sync #(
    .W        (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (sync_in),
    .sync_out (sync_lvl)
  );

  logic sen_s;
  logic mirror_s;
  logic reset_s;
  logic gate_s;
  logic scan_serial_out_s;

  assign sen_s    = sync_lvl[SYNC_SEN];
  assign mirror_s = sync_lvl[SYNC_MIRROR];
  assign reset_s  = sync_lvl[SYNC_RESET];
  assign gate_s   = sync_lvl[SYNC_GATE];
  assign scan_serial_out_s   = sync_lvl[SYNC_SCAN_SERIAL_OUT];

  typedef struct packed {
    logic                 strobe_o;
    logic                 strobe_oe;
    logic                 mirror;
    logic                 core_reset;
    logic                 ca_nominal;
    logic                 dq_off;
    logic                 active;
    logic                 used;
    logic                 in_ready;
    logic                 out_valid;
    logic [CMD_W-1:0]     out_data;
  } mbs_core_st_t;

  mbs_core_st_t cs_q;
  mbs_core_st_t cs_d;

  logic                 cmd_block;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [CMD_W-1:0]     fifo_out_data;
  logic                 fifo_pop;
  logic                 push;
  logic [FIFO_CW-1:0]   fifo_cnt;
  logic [FIFO_CW-1:0]   cnt_next;
  logic                 scan_ok;

  // Scan only counts once the core reports initialisation complete
  assign scan_ok = sen_s && init_done;

  // Once scan has been used the array stays closed until power-on reset
  assign cmd_block = sen_s || cs_q.used;

  assign push     = cmd_in_valid && cs_q.in_ready && fifo_in_ready;
  assign fifo_pop = fifo_out_valid && (!cs_q.out_valid || cmd_out_ready) && !cmd_block;
  assign cnt_next = fifo_cnt + FIFO_CW'(push) - FIFO_CW'(fifo_pop);

  // Commands queue here; back-pressure from the array reaches the source
  mbs_fifo #(
    .W         (CMD_W),
    .DEPTH     (FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (cmd_block),
    .in_valid  (push),
    .in_data   (cmd_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_pop),
    .count     (fifo_cnt)
  );

  always_comb
  begin
    cs_d = cs_q;

    // Strobe pin turns round to scan output only in scan mode with the gate taken
    cs_d.strobe_oe = scan_ok && gate_s;
    cs_d.strobe_o  = scan_ok && gate_s && scan_serial_out_s;

    // Mirror follows its pin in normal mode only
    cs_d.mirror = !sen_s && mirror_s;

    // Reset pin is shift select in scan mode; core keeps its last level
    if (!sen_s)
    begin
      cs_d.core_reset = reset_s;
    end

    cs_d.ca_nominal = sen_s;
    cs_d.dq_off     = sen_s;
    cs_d.active     = scan_ok;
    if (scan_ok)
    begin
      cs_d.used = BIT_SET;
    end

    // Registered ready with exact room accounting, so no word is dropped
    cs_d.in_ready = !cmd_block && (cnt_next < FIFO_CW'(FIFO_DEPTH));

    // Output stage toward the array
    if (cmd_block)
    begin
      cs_d.out_valid = BIT_CLR;
    end
    else if (fifo_pop)
    begin
      cs_d.out_valid = BIT_SET;
      cs_d.out_data  = fifo_out_data;
    end
    else if (cmd_out_ready)
    begin
      cs_d.out_valid = BIT_CLR;
    end

    if (!rst_n)
    begin
      cs_d            = '0;
      cs_d.core_reset = BIT_CLR;
    end
  end

  always_ff @(posedge clk)
  begin
    cs_q <= cs_d;
  end

  assign lane0_write_strobe_o  = cs_q.strobe_o;
  assign lane0_write_strobe_oe = cs_q.strobe_oe;
  assign mirror_active         = cs_q.mirror;
  assign core_reset_level      = cs_q.core_reset;
  assign ca_term_nominal       = cs_q.ca_nominal;
  assign dq_term_off           = cs_q.dq_off;
  assign scan_active           = cs_q.active;
  assign scan_used             = cs_q.used;
  assign cmd_in_ready          = cs_q.in_ready;
  assign cmd_out_valid         = cs_q.out_valid;
  assign cmd_out_data          = cs_q.out_data;

  // The strobe input is the write path's in normal mode; it is not read here
  logic unused_strobe;
  assign unused_strobe = lane0_write_strobe_i;

endmodule

// ==== mbs_scan_port_props.sv ====
// Concurrent checks on the scan port outputs
`timescale 1ns/100ps
module mbs_scan_port_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scan_mode_select,
  input wire logic device_reset_pin,
  input wire logic ball_mirror_select,
  input wire logic lane0_write_strobe_oe,
  input wire logic mirror_active,
  input wire logic core_reset_level,
  input wire logic ca_term_nominal,
  input wire logic dq_term_off,
  input wire logic scan_active,
  input wire logic scan_used,
  input wire logic cmd_in_ready,
  input wire logic cmd_out_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_cmd_block; scan_used && $past(scan_used) |-> !cmd_in_ready; endproperty
  a_cmd_block: assert property (p_cmd_block) else $error("command input open");
  property p_out_drop; scan_used && $past(scan_used) |-> !cmd_out_valid; endproperty
  a_out_drop: assert property (p_out_drop) else $error("command output live");
  property p_oe_scan; lane0_write_strobe_oe |-> scan_used; endproperty
  a_oe_scan: assert property (p_oe_scan) else $error("strobe driven outside scan");
  property p_mirror_off; scan_active |-> !mirror_active && ca_term_nominal; endproperty
  a_mirror_off: assert property (p_mirror_off) else $error("mirror on in scan");
  property p_term_pair;
    $past(rst_n, 3) |->
      ca_term_nominal == $past(scan_mode_select, 3) && dq_term_off == ca_term_nominal;
  endproperty
  a_term_pair: assert property (p_term_pair) else $error("termination split");
  property p_reset_hold; ca_term_nominal |-> $stable(core_reset_level); endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset level moved");
  property p_mirror_follow;
    $past(rst_n, 3) |->
      mirror_active == ($past(ball_mirror_select, 3) && !$past(scan_mode_select, 3));
  endproperty
  a_mirror_follow: assert property (p_mirror_follow) else $error("mirror level wrong");
  property p_reset_follow;
    $past(rst_n, 3) && !ca_term_nominal |-> core_reset_level == $past(device_reset_pin, 3);
  endproperty
  a_reset_follow: assert property (p_reset_follow) else $error("reset pin lost");
  c_scan_out: cover property (scan_active && lane0_write_strobe_oe);
  c_cmd_out: cover property (cmd_out_valid);
  c_refused: cover property (ca_term_nominal && !scan_used);
endmodule
bind mbs_scan_port mbs_scan_port_props u_props (
  .clk, .rst_n, .scan_mode_select, .device_reset_pin, .ball_mirror_select,
  .lane0_write_strobe_oe, .mirror_active, .core_reset_level, .ca_term_nominal,
  .dq_term_off, .scan_active, .scan_used, .cmd_in_ready, .cmd_out_valid
);

// ==== mbs_sync.sv ====
// Two flip-flop level synchroniser, one bit per lane
`timescale 1ns/100ps
module mbs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } mbs_sync_st_t;

  mbs_sync_st_t st_q;
  mbs_sync_st_t st_d;

  always_comb
  begin
    st_d        = st_q;
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
    if (!rst_n)
    begin
      st_d = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    st_q <= st_d;
  end

  assign sync_out = st_q.stable;

endmodule

// ==== mbs_tester.sv ====
// Behavioural scan tester driving the scan pins of the port
`timescale 1ns/100ps
module mbs_tester
  import mbs_pkg::*;
(
  output logic                            scan_clk,
  output logic                            scan_mode_select,
  output logic                            device_reset_pin,
  output logic                            ball_mirror_select,
  output logic [mbs_pkg::CHAIN_LEN-1:0]   pad_level
);
  initial
  begin
    scan_clk = 1'b0;
    scan_mode_select = 1'b0;
    device_reset_pin = 1'b1;
    ball_mirror_select = 1'b1;
    pad_level = '0;
  end
  // Select moves well ahead of the next scan clock edge
  task automatic set_sel(input logic v);
    scan_mode_select = v;
    #40;
  endtask
  task automatic load(input logic [CHAIN_LEN-1:0] p);
    pad_level = p;
  endtask
  // One isolated pulse; the scan clock stands still afterwards
  task automatic pulse(input logic shift, input logic gate);
    device_reset_pin = shift;
    ball_mirror_select = gate;
    #40;
    scan_clk = 1'b1;
    #80;
    scan_clk = 1'b0;
    #40;
  endtask
endmodule

// ==== tb_memory_boundary_scan_port.sv ====
// Self-checking testbench for the memory boundary scan port
`timescale 1ns/100ps
module tb_memory_boundary_scan_port;
  import mbs_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 init_done = 1'b0;
  logic                 cmd_in_valid = 1'b0;
  logic [CMD_W-1:0]     cmd_in_data = 16'h0000;
  logic                 cmd_out_ready = 1'b0;
  logic                 scan_clk, scan_mode_select, device_reset_pin, ball_mirror_select;
  logic [CHAIN_LEN-1:0] pad_level;
  logic                 lane0_write_strobe_i, lane0_write_strobe_o, lane0_write_strobe_oe;
  logic                 mirror_active, core_reset_level, ca_term_nominal, dq_term_off;
  logic                 scan_active, scan_used, cmd_in_ready, cmd_out_valid;
  logic [CMD_W-1:0]     cmd_out_data;
  int                   fail_count = 0;
  int                   checks = 0;
  int                   cycles = 0;
  always #12.5 clk = ~clk;
  // Undriven strobe line shows a moving pattern, never a held value
  assign lane0_write_strobe_i = lane0_write_strobe_oe ? lane0_write_strobe_o : ~clk;
  mbs_scan_port u_dut (
    .clk, .rst_n, .scan_clk, .scan_mode_select, .device_reset_pin, .ball_mirror_select,
    .pad_level, .lane0_write_strobe_i, .lane0_write_strobe_o, .lane0_write_strobe_oe,
    .init_done, .mirror_active, .core_reset_level, .ca_term_nominal, .dq_term_off,
    .scan_active, .scan_used, .cmd_in_valid, .cmd_in_data, .cmd_in_ready, .cmd_out_valid,
    .cmd_out_data, .cmd_out_ready
  );
  mbs_tester u_tester (
    .scan_clk, .scan_mode_select, .device_reset_pin, .ball_mirror_select, .pad_level
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  // Fill the command buffer until refused, then drain in order
  task automatic t_cmd;
    int   n;
    int   w;
    logic acc;
    n = 0;
    check(mirror_active, 1'b1);
    check(core_reset_level, 1'b1);
    @(posedge clk);
    cmd_in_valid <= 1'b1;
    cmd_in_data <= 16'h1000;
    repeat (40)
    begin
      @(negedge clk);
      acc = cmd_in_ready;
      @(posedge clk);
      if (acc)
      begin
        n++;
        cmd_in_data <= 16'h1000 + 16'(n);
      end
    end
    cmd_in_valid <= 1'b0;
    cmd_out_ready <= 1'b1;
    check(16'(n), 16'(FIFO_DEPTH + 1));
    for (int k = 0; k < FIFO_DEPTH + 1; k++)
    begin
      w = 0;
      @(negedge clk);
      while (cmd_out_valid !== 1'b1 && w < 20)
      begin
        @(negedge clk);
        w++;
      end
      check(cmd_out_data, 16'h1000 + 16'(k));
    end
    $display("t_cmd done");
  endtask
  task automatic t_noinit;
    u_tester.set_sel(1'b1);
    u_tester.pulse(1'b0, 1'b1);
    repeat (6) @(negedge clk);
    check(lane0_write_strobe_oe, 1'b0);
    check(scan_used, 1'b0);
    check(cmd_in_ready, 1'b0);
    check(mirror_active, 1'b0);
    check({ca_term_nominal, dq_term_off}, 2'h3);
    u_tester.set_sel(1'b0);
    u_tester.pulse(1'b1, 1'b1);
    repeat (6) @(negedge clk);
    check(cmd_in_ready, 1'b1);
    check(mirror_active, 1'b1);
    $display("t_noinit done");
  endtask
  // Capture a pattern and shift the whole chain plus two extra bits out
  task automatic t_scan;
    logic [CHAIN_LEN-1:0] p;
    logic                 e;
    p = 67'h7_FFAB_CDEF_9ABC_DEF0;
    u_tester.load(p);
    @(posedge clk);
    init_done <= 1'b1;
    @(negedge clk);
    u_tester.set_sel(1'b1);
    u_tester.pulse(1'b0, 1'b1);
    @(posedge clk);
    cmd_in_valid <= 1'b1;
    for (int b = 1; b <= CHAIN_LEN + 2; b++)
    begin
      repeat (3) @(negedge clk);
      e = (b > CHAIN_LEN || b == 20 || b == 56 || b == 57) ? 1'b0 : p[b-1];
      check(lane0_write_strobe_oe, 1'b1);
      check(lane0_write_strobe_i, e);
      u_tester.pulse(1'b1, 1'b1);
    end
    u_tester.pulse(1'b1, 1'b0);
    repeat (3) @(negedge clk);
    check(lane0_write_strobe_oe, 1'b0);
    check(cmd_out_valid, 1'b0);
    u_tester.set_sel(1'b0);
    u_tester.pulse(1'b1, 1'b1);
    repeat (6) @(negedge clk);
    check(lane0_write_strobe_oe, 1'b0);
    check(cmd_in_ready, 1'b0);
    @(posedge clk);
    cmd_in_valid <= 1'b0;
    $display("t_scan done");
  endtask
  task automatic t_cycle;
    @(posedge clk);
    rst_n <= 1'b0;
    init_done <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    init_done <= 1'b1;
    repeat (4) @(negedge clk);
    check(scan_used, 1'b0);
    check(cmd_in_ready, 1'b1);
    $display("t_cycle done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    u_tester.pulse(1'b1, 1'b1);
    repeat (4) @(negedge clk);
    t_cmd();
    t_noinit();
    t_scan();
    t_cycle();
    wrap_up();
  end
endmodule
